// ===== core/cssu_pkg.sv
package cssu_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE     = 8'h00;
  localparam logic [7:0] ADDR_CTRL     = 8'h04;
  localparam logic [7:0] ADDR_PERIOD   = 8'h08;
  localparam logic [7:0] ADDR_PHASE    = 8'h0C;
  localparam logic [7:0] ADDR_TXBUF    = 8'h10;
  localparam logic [7:0] ADDR_RXBUF    = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;

  // ----------------------------------------------------------------
  // counts and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]  CHAR_BITS     = 4'h8;
  localparam logic [3:0]  BIT_LAST      = 4'h7;
  localparam logic [16:0] PERIOD_OFFSET = 17'h00001;
  localparam logic        TX_IDLE_LEVEL = 1'b1;
  localparam int          SYNC_W        = 2;

  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tx_polarity_select;
    logic rx_polarity_select;
    logic tx_irq_source_select;
    logic bit_order_select;
    logic clock_invert_select;
    logic clock_idle_level;
    logic clock_source_select;
  } cssu_mode_s;

  typedef struct packed {
    logic rx_enable_bit;
    logic tx_enable_bit;
  } cssu_ctrl_s;

  typedef struct packed {
    logic       rx_complete_flag;
    logic       tx_shifter_empty_flag;
    logic       tx_buffer_empty_flag;
    logic [5:0] rsvd;
    cssu_ctrl_s ctrl;
  } cssu_ctrl_rd_s;

  typedef struct packed {
    logic overrun;
    logic rx_done;
    logic tx_event;
  } cssu_irq_s;

  typedef struct packed {
    logic       overrun;
    logic [7:0] data;
  } cssu_rxbuf_s;

  localparam cssu_mode_s MODE_RST = 7'h00;
  localparam cssu_ctrl_s CTRL_RST = 2'h0;
  localparam cssu_irq_s  IRQ_RST  = 3'h0;

  typedef enum logic [0:0] {
    SER_IDLE,
    SER_RUN
  } cssu_ser_e;

endpackage

// ===== core/cssu_sync.sv
module cssu_sync (
  input  wire logic                      mclk_in,
  input  wire logic                      rst_in,
  input  wire logic [cssu_pkg::SYNC_W-1:0] d_in,
  output logic      [cssu_pkg::SYNC_W-1:0] q_out
);

  typedef struct packed {
    logic [cssu_pkg::SYNC_W-1:0] meta;
    logic [cssu_pkg::SYNC_W-1:0] q;
  } cssu_sync_s;

  cssu_sync_s s_reg;
  cssu_sync_s s_next;

  // ----------------------------------------------------------------
  // two-stage synchroniser, first stage read only by the second
  // ----------------------------------------------------------------
  always_comb begin
    s_next      = s_reg;
    s_next.meta = d_in;
    s_next.q    = s_reg.meta;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q_out = s_reg.q;

endmodule // cssu_sync

// ===== core/cssu_clkgen.sv
module cssu_clkgen (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        run_in,
  input  wire logic [15:0] period_in,
  output logic             lead_out,
  output logic             trail_out,
  output logic             phase_out
);

  typedef struct packed {
    logic [16:0] cnt;
    logic        phase;
    logic        lead;
    logic        trail;
  } cssu_gen_s;

  cssu_gen_s   s_reg;
  cssu_gen_s   s_next;
  logic [16:0] term;

  // ----------------------------------------------------------------
  // half period of n+2 base cycles
  // ----------------------------------------------------------------
  always_comb begin
    s_next       = s_reg;
    s_next.lead  = 1'b0;
    s_next.trail = 1'b0;
    term         = {1'b0, period_in} + cssu_pkg::PERIOD_OFFSET;
    if (!run_in) begin
      s_next.cnt   = '0;
      s_next.phase = 1'b0;
    end else if (s_reg.cnt == term) begin
      s_next.cnt   = '0;
      s_next.phase = ~s_reg.phase;
      s_next.lead  = ~s_reg.phase;
      s_next.trail = s_reg.phase;
    end else begin
      s_next.cnt = s_reg.cnt + 17'h00001;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign lead_out  = s_reg.lead;
  assign trail_out = s_reg.trail;
  assign phase_out = s_reg.phase;

endmodule // cssu_clkgen

// ===== core/cssu_top.sv
// The implementer's own choices: the APB interface to the registers and the register addresses.
module cssu_top (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             irq_out,
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe_out,
  input  wire logic        serial_rx_pin_in,
  output logic             serial_tx_pin_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    cssu_pkg::cssu_mode_s  mode;
    cssu_pkg::cssu_ctrl_s  ctrl;
    logic [15:0]           period_compare_value;
    logic [15:0]           phase_compare_value;
    logic [7:0]            tx_buffer;
    logic                  tx_buffer_empty_flag;
    logic                  tx_shifter_empty_flag;
    logic [7:0]            tx_shifter;
    logic [7:0]            rx_shifter;
    cssu_pkg::cssu_rxbuf_s rx_buffer;
    logic                  rx_complete_flag;
    logic [3:0]            bit_cnt;
    cssu_pkg::cssu_ser_e   ser_state;
    logic                  ext_clk_prev;
    cssu_pkg::cssu_irq_s   irq_stat;
    cssu_pkg::cssu_irq_s   irq_mask;
    logic                  irq;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  tx_pin;
    logic                  sclk_pin;
    logic                  sclk_oe;
  } cssu_state_s;

  cssu_state_s                 s_reg;
  cssu_state_s                 s_next;
  logic [cssu_pkg::SYNC_W-1:0] pin_sync;
  logic                        gen_lead;
  logic                        gen_trail;
  logic                        gen_phase;
  logic                        gen_run;
  logic                        internal_clk;
  logic                        ext_clk;
  logic                        rx_bit;
  logic                        edge_lead;
  logic                        edge_trail;
  logic                        rx_active;
  logic                        access;
  logic                        commit;
  logic [7:0]                  rx_next;
  cssu_pkg::cssu_irq_s         ev;
  cssu_pkg::cssu_irq_s         w1c;
  cssu_pkg::cssu_ctrl_rd_s     ctrl_rd;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic out_bit(input logic [7:0] sh, input logic msb_first);
    out_bit = msb_first ? sh[7] : sh[0];
  endfunction

  function automatic logic tx_level(input logic [7:0] sh, input cssu_pkg::cssu_mode_s m);
    tx_level = out_bit(sh, m.bit_order_select) ^ m.tx_polarity_select;
  endfunction

  function automatic logic [7:0] shift_tx(input logic [7:0] sh, input logic msb_first);
    shift_tx = msb_first ? {sh[6:0], 1'b0} : {1'b0, sh[7:1]};
  endfunction

  function automatic logic [7:0] shift_rx(input logic [7:0] sh, input logic msb_first,
                                          input logic b);
    shift_rx = msb_first ? {sh[6:0], b} : {b, sh[7:1]};
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      cssu_pkg::ADDR_MODE,
      cssu_pkg::ADDR_CTRL,
      cssu_pkg::ADDR_PERIOD,
      cssu_pkg::ADDR_PHASE,
      cssu_pkg::ADDR_TXBUF,
      cssu_pkg::ADDR_RXBUF,
      cssu_pkg::ADDR_IRQ_STAT,
      cssu_pkg::ADDR_IRQ_MASK: mapped = 1'b1;
      default:                 mapped = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and internal clock
  // ----------------------------------------------------------------
  cssu_sync u_sync (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .d_in    ({serial_clock_pin_in, serial_rx_pin_in}),
    .q_out   (pin_sync)
  );

  assign internal_clk = !s_reg.mode.clock_source_select;
  assign gen_run      = internal_clk && (s_reg.ser_state == cssu_pkg::SER_RUN);
  assign ext_clk      = pin_sync[1];

  cssu_clkgen u_clkgen (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .run_in    (gen_run),
    .period_in (s_reg.period_compare_value),
    .lead_out  (gen_lead),
    .trail_out (gen_trail),
    .phase_out (gen_phase)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next  = s_reg;
    ev      = '0;
    w1c     = '0;
    rx_next = '0;
    ctrl_rd = '0;

    // ---------------------------------------------------------------
    // clock edges and receive bit
    // ---------------------------------------------------------------
    // receive inversion
    rx_bit     = pin_sync[0] ^ s_reg.mode.rx_polarity_select;
    edge_lead  = internal_clk ? gen_lead : (ext_clk && !s_reg.ext_clk_prev);
    edge_trail = internal_clk ? gen_trail : (!ext_clk && s_reg.ext_clk_prev);
    rx_active  = s_reg.ctrl.tx_enable_bit || s_reg.ctrl.rx_enable_bit;
    access     = psel_in && penable_in;
    commit     = access && s_reg.pready;

    // ---------------------------------------------------------------
    // external clock history
    // ---------------------------------------------------------------
    s_next.ext_clk_prev = ext_clk;

    // ---------------------------------------------------------------
    // serial engine
    // ---------------------------------------------------------------
    case (s_reg.ser_state)
      cssu_pkg::SER_IDLE: begin
        if (s_reg.ctrl.tx_enable_bit && !s_reg.tx_buffer_empty_flag) begin
          s_next.tx_shifter            = s_reg.tx_buffer;
          s_next.tx_buffer_empty_flag  = 1'b1;
          s_next.tx_shifter_empty_flag = 1'b0;
          s_next.bit_cnt               = '0;
          s_next.ser_state             = cssu_pkg::SER_RUN;
          s_next.tx_pin = tx_level(s_reg.tx_buffer, s_reg.mode);
          ev.tx_event = !s_reg.mode.tx_irq_source_select;
        end
      end
      cssu_pkg::SER_RUN: begin
        if (!s_reg.ctrl.tx_enable_bit) begin
          s_next.ser_state             = cssu_pkg::SER_IDLE;
          s_next.tx_shifter_empty_flag = 1'b1;
        end else if (edge_lead) begin
          rx_next           = shift_rx(s_reg.rx_shifter, s_reg.mode.bit_order_select, rx_bit);
          s_next.rx_shifter = rx_next;
          s_next.bit_cnt    = s_reg.bit_cnt + 4'h1;
          if (s_reg.bit_cnt == cssu_pkg::BIT_LAST && rx_active) begin
            s_next.rx_buffer.data    = rx_next;
            s_next.rx_buffer.overrun = s_reg.rx_complete_flag;
            s_next.rx_complete_flag  = 1'b1;
            ev.rx_done               = 1'b1;
            ev.overrun               = s_reg.rx_complete_flag;
          end
        end else if (edge_trail) begin
          if (s_reg.bit_cnt == cssu_pkg::CHAR_BITS) begin
            ev.tx_event = s_reg.mode.tx_irq_source_select;
            s_next.bit_cnt = '0;
            if (!s_reg.tx_buffer_empty_flag) begin
              s_next.tx_shifter           = s_reg.tx_buffer;
              s_next.tx_buffer_empty_flag = 1'b1;
              s_next.tx_pin = tx_level(s_reg.tx_buffer, s_reg.mode);
              if (!s_reg.mode.tx_irq_source_select) begin
                ev.tx_event = 1'b1;
              end
            end else begin
              s_next.ser_state             = cssu_pkg::SER_IDLE;
              s_next.tx_shifter_empty_flag = 1'b1;
            end
          end else begin
            s_next.tx_shifter = shift_tx(s_reg.tx_shifter, s_reg.mode.bit_order_select);
            s_next.tx_pin = tx_level(s_next.tx_shifter, s_reg.mode);
          end
        end
      end
      default: begin
        s_next.ser_state = cssu_pkg::SER_IDLE;
      end
    endcase

    // ---------------------------------------------------------------
    // serial clock pin
    // ---------------------------------------------------------------
    s_next.sclk_oe = internal_clk;
    s_next.sclk_pin = s_reg.mode.clock_idle_level ^ s_reg.mode.clock_invert_select
                      ^ (gen_run && gen_phase);

    // ---------------------------------------------------------------
    // apb slave, one wait state
    // ---------------------------------------------------------------
    // status flags readable
    ctrl_rd.ctrl                  = s_reg.ctrl;
    ctrl_rd.tx_buffer_empty_flag  = s_reg.tx_buffer_empty_flag;
    ctrl_rd.tx_shifter_empty_flag = s_reg.tx_shifter_empty_flag;
    ctrl_rd.rx_complete_flag      = s_reg.rx_complete_flag;

    // ---------------------------------------------------------------
    // read response
    // ---------------------------------------------------------------
    if (access && !s_reg.pready) begin
      s_next.pready  = 1'b1;
      s_next.pslverr = !mapped(paddr_in);
      case (paddr_in)
        cssu_pkg::ADDR_MODE:     s_next.prdata = 32'(s_reg.mode);
        cssu_pkg::ADDR_CTRL:     s_next.prdata = 32'(ctrl_rd);
        cssu_pkg::ADDR_PERIOD:   s_next.prdata = 32'(s_reg.period_compare_value);
        cssu_pkg::ADDR_PHASE:    s_next.prdata = 32'(s_reg.phase_compare_value);
        cssu_pkg::ADDR_TXBUF:    s_next.prdata = 32'(s_reg.tx_buffer);
        cssu_pkg::ADDR_RXBUF:    s_next.prdata = 32'(s_reg.rx_buffer);
        cssu_pkg::ADDR_IRQ_STAT: s_next.prdata = 32'(s_reg.irq_stat);
        cssu_pkg::ADDR_IRQ_MASK: s_next.prdata = 32'(s_reg.irq_mask);
        default:                 s_next.prdata = '0;
      endcase
    end else begin
      s_next.pready  = 1'b0;
      s_next.pslverr = 1'b0;
    end

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    if (commit && pwrite_in) begin
      case (paddr_in)
        cssu_pkg::ADDR_MODE: begin
          s_next.mode = pwdata_in[$bits(cssu_pkg::cssu_mode_s)-1:0];
        end
        cssu_pkg::ADDR_CTRL: begin
          s_next.ctrl = pwdata_in[$bits(cssu_pkg::cssu_ctrl_s)-1:0];
        end
        cssu_pkg::ADDR_PERIOD: begin
          s_next.period_compare_value = pwdata_in[15:0];
        end
        cssu_pkg::ADDR_PHASE: begin
          s_next.phase_compare_value = pwdata_in[15:0];
        end
        cssu_pkg::ADDR_TXBUF: begin
          s_next.tx_buffer            = pwdata_in[7:0];
          s_next.tx_buffer_empty_flag = 1'b0;
        end
        cssu_pkg::ADDR_IRQ_STAT: begin
          w1c = pwdata_in[$bits(cssu_pkg::cssu_irq_s)-1:0];
        end
        cssu_pkg::ADDR_IRQ_MASK: begin
          s_next.irq_mask = pwdata_in[$bits(cssu_pkg::cssu_irq_s)-1:0];
        end
        default: begin
          s_next.irq_mask = s_reg.irq_mask;
        end
      endcase
    end

    // ---------------------------------------------------------------
    // receive buffer read
    // ---------------------------------------------------------------
    // reading the receive buffer clears completion unless a new one lands
    if (commit && !pwrite_in && paddr_in == cssu_pkg::ADDR_RXBUF && !ev.rx_done) begin
      s_next.rx_complete_flag = 1'b0;
    end

    // ---------------------------------------------------------------
    // interrupts, set wins over clear
    // ---------------------------------------------------------------
    s_next.irq_stat = (s_reg.irq_stat & ~w1c) | ev;
    s_next.irq      = |(s_next.irq_stat & s_next.irq_mask);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_reg                       <= '0;
      s_reg.mode                  <= cssu_pkg::MODE_RST;
      s_reg.ctrl                  <= cssu_pkg::CTRL_RST;
      s_reg.irq_stat              <= cssu_pkg::IRQ_RST;
      s_reg.irq_mask              <= cssu_pkg::IRQ_RST;
      s_reg.tx_buffer_empty_flag  <= 1'b1;
      s_reg.tx_shifter_empty_flag <= 1'b1;
      s_reg.tx_pin                <= cssu_pkg::TX_IDLE_LEVEL;
      s_reg.ser_state             <= cssu_pkg::SER_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata_out              = s_reg.prdata;
  assign pready_out              = s_reg.pready;
  assign pslverr_out             = s_reg.pslverr;
  assign irq_out                 = s_reg.irq;
  assign serial_clock_pin_out    = s_reg.sclk_pin;
  assign serial_clock_pin_oe_out = s_reg.sclk_oe;
  assign serial_tx_pin_out       = s_reg.tx_pin;

endmodule // cssu_top

// ===== verif/cssu_checker.sv
module cssu_checker (
  input wire logic        mclk_in,
  input wire logic        rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        irq_out,
  input wire logic        serial_clock_pin_in,
  input wire logic        serial_clock_pin_out,
  input wire logic        serial_clock_pin_oe_out,
  input wire logic        serial_rx_pin_in,
  input wire logic        serial_tx_pin_out
);
  // ----------------------------------------------------------------
  // bus and pin relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence s_start;
    psel_in && $rose(penable_in);
  endsequence
  sequence s_answer;
    pready_out ##1 !pready_out;
  endsequence
  wire logic wr_done = pready_out && pwrite_in;

  AST_APB_ONE_WAIT: assert property (s_start |=> s_answer)
    else $error("answer not one cycle after access");
  AST_READY_CAUSE: assert property (pready_out |-> $past(psel_in && penable_in))
    else $error("answer without access");
  AST_SLVERR_WITH_READY: assert property (pslverr_out |-> pready_out)
    else $error("error flag outside answer");
  AST_ERR_READ_ZERO: assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
    else $error("refused read returned data");
  AST_RESET_PINS: assert property (disable iff (1'b0) rst_in |=> serial_tx_pin_out && !irq_out
    && !pready_out && !serial_clock_pin_oe_out)
    else $error("outputs not at reset level");
  AST_OE_AFTER_RELEASE: assert property ($fell(rst_in) |-> ##1 serial_clock_pin_oe_out)
    else $error("internal clock not driven after reset");
  AST_SCLK_HOLD: assert property (serial_clock_pin_oe_out && $past(serial_clock_pin_oe_out)
    && $changed(serial_clock_pin_out) |=> $stable(serial_clock_pin_out))
    else $error("serial clock edge too close");
  AST_IRQ_FALL: assert property ($fell(irq_out) |-> $past(wr_done) || $past(wr_done, 2)
    || $past(rst_in))
    else $error("interrupt dropped without a write");
endmodule // cssu_checker

bind cssu_top cssu_checker cssu_checker_i (.mclk_in(mclk_in), .rst_in(rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .irq_out(irq_out), .serial_clock_pin_in(serial_clock_pin_in),
  .serial_clock_pin_out(serial_clock_pin_out),
  .serial_clock_pin_oe_out(serial_clock_pin_oe_out),
  .serial_rx_pin_in(serial_rx_pin_in), .serial_tx_pin_out(serial_tx_pin_out));

// ===== verif/cssu_partner.sv
module cssu_partner (
  input  wire logic       mclk_in,
  input  wire logic       start_in,
  input  wire logic       sclk_in,
  input  wire logic       idle_in,
  input  wire logic       msb_in,
  input  wire logic       tx_in,
  input  wire logic [7:0] send_in,
  output logic            rx_out,
  output logic [7:0]      got_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // far side peripheral
  // ----------------------------------------------------------------
  logic       prev = 1'b0;
  logic [3:0] idx  = 4'h8;
  logic [2:0] sel;
  initial got_out = 8'h00;
  assign sel = msb_in ? 3'(4'h7 - idx) : idx[2:0];
  // sample on leading edge, shift on trailing edge
  always @(posedge mclk_in) begin
    prev <= sclk_in;
    if (start_in)
      idx <= 4'h0;
    else if (prev == idle_in && sclk_in != idle_in)
      got_out <= msb_in ? {got_out[6:0], tx_in} : {tx_in, got_out[7:1]};
    else if (prev != idle_in && sclk_in == idle_in && idx < 4'h8)
      idx <= idx + 4'h1;
  end
  // released line shows the inverse of the last bit
  assign rx_out = (idx < 4'h8) ? send_in[sel] : ~(msb_in ? send_in[0] : send_in[7]);
endmodule // cssu_partner

// ===== verif/test_clock_sync_serial_unit.sv
module test_clock_sync_serial_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_in = 1'b0, rst_in = 1'b1;
  logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, rd = 32'h0;
  logic        err, ext_clk = 1'b0, p_start = 1'b0, p_idle = 1'b0, p_msb = 1'b0, lprev = 1'b0;
  logic [7:0]  p_send = 8'h00;
  wire  [31:0] prdata_out;
  wire  [7:0]  p_got;
  wire         pready_out, pslverr_out, irq_out, sclk_out, sclk_oe, tx, rx;
  wire         sclk_w = sclk_oe ? sclk_out : ext_clk;
  int          mismatches = 0, checks = 0, cycles = 0, per_seen = 0, per_cnt = 0;
  logic [6:0]  md [5] = '{7'h00, 7'h0A, 7'h14, 7'h60, 7'h09};
  logic [15:0] nv [5] = '{16'h0002, 16'h0003, 16'h0002, 16'h0004, 16'h0002};
  logic [7:0]  tdv [5] = '{8'hA5, 8'h81, 8'h5A, 8'hF0, 8'h37};
  logic [7:0]  sd [5] = '{8'h3C, 8'hC6, 8'h0F, 8'h96, 8'hE1};
  logic [2:0]  msk [5] = '{3'h0, 3'h2, 3'h1, 3'h4, 3'h2};

  cssu_top cssu_top_i (.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .irq_out(irq_out), .serial_clock_pin_in(sclk_w),
    .serial_clock_pin_out(sclk_out), .serial_clock_pin_oe_out(sclk_oe),
    .serial_rx_pin_in(rx), .serial_tx_pin_out(tx));
  cssu_partner cssu_partner_i (.mclk_in(mclk_in), .start_in(p_start), .sclk_in(sclk_w),
    .idle_in(p_idle), .msb_in(p_msb), .tx_in(tx), .send_in(p_send), .rx_out(rx),
    .got_out(p_got));

  // ----------------------------------------------------------------
  // clock, timeout, serial period monitor
  // ----------------------------------------------------------------
  initial forever #12.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    lprev <= sclk_w;
    per_cnt <= per_cnt + 1;
    if (lprev == p_idle && sclk_w != p_idle) begin
      per_seen <= per_cnt;
      per_cnt <= 1;
    end
    if (cycles == 20000) begin
      mismatches++;
      final_report;
    end
  end

  task final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do @(posedge mclk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, exp, rd);
  endtask

  task frame(input int i);
    logic [6:0] m;
    m = md[i];
    p_idle <= m[0] ? 1'b0 : m[1] ^ m[2];
    p_msb <= m[3];
    p_send <= sd[i];
    apb(1'b1, cssu_pkg::ADDR_IRQ_MASK, {29'h0, msk[i]});
    apb(1'b1, cssu_pkg::ADDR_PERIOD, {16'h0, nv[i]});
    apb(1'b1, cssu_pkg::ADDR_PHASE, {16'h0, nv[i] - 16'h1});
    apb(1'b1, cssu_pkg::ADDR_MODE, {25'h0, m});
    repeat (2) @(posedge mclk_in);
    check("clock enable", {31'h0, ~m[0]}, {31'h0, sclk_oe});
    @(posedge mclk_in) p_start <= 1'b1;
    @(posedge mclk_in) p_start <= 1'b0;
    apb(1'b1, cssu_pkg::ADDR_CTRL, 32'h1);
    apb(1'b1, cssu_pkg::ADDR_TXBUF, {24'h0, tdv[i]});
    rdc(cssu_pkg::ADDR_IRQ_STAT, {31'h0, ~m[4]}, "early tx event");
    if (m[0])
      repeat (8) begin
        repeat (8) @(posedge mclk_in);
        ext_clk <= 1'b1;
        repeat (8) @(posedge mclk_in);
        ext_clk <= 1'b0;
      end
    for (int k = 0; k < 300 && rd[10:8] !== 3'h7; k++)
      apb(1'b0, cssu_pkg::ADDR_CTRL, 32'h0);
    check("ctrl flags", 32'h701, rd);
    rdc(cssu_pkg::ADDR_RXBUF, {24'h0, m[5] ? ~sd[i] : sd[i]}, "rx data");
    check("tx data", {24'h0, m[6] ? ~tdv[i] : tdv[i]}, {24'h0, p_got});
    if (!m[0])
      check("clock period", 32'(2 * (nv[i] + 2)), per_seen);
    if (!m[0])
      check("clock idle", {31'h0, m[1] ^ m[2]}, {31'h0, sclk_out});
    rdc(cssu_pkg::ADDR_IRQ_STAT, 32'h3, "irq status");
    check("irq", {31'h0, |msk[i][1:0]}, {31'h0, irq_out});
    apb(1'b1, cssu_pkg::ADDR_IRQ_STAT, 32'h7);
    rdc(cssu_pkg::ADDR_IRQ_STAT, 32'h0, "irq cleared");
    check("irq low", 32'h0, {31'h0, irq_out});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    check("tx idle", 32'h1, {31'h0, tx});
    rdc(cssu_pkg::ADDR_CTRL, 32'h300, "ctrl reset");
    rdc(cssu_pkg::ADDR_MODE, 32'h0, "mode reset");
    rdc(cssu_pkg::ADDR_IRQ_MASK, 32'h0, "mask reset");
    rdc(8'h20, 32'h0, "unmapped read");
    check("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, 8'h22, 32'hFF);
    check("unaligned error", 32'h1, {31'h0, err});
    for (int i = 0; i < 5; i++)
      frame(i);
    // two characters back to back, the second overruns the unread buffer
    p_msb <= 1'b0;
    apb(1'b1, cssu_pkg::ADDR_MODE, 32'h0);
    apb(1'b1, cssu_pkg::ADDR_IRQ_MASK, 32'h4);
    apb(1'b1, cssu_pkg::ADDR_TXBUF, 32'hC3);
    apb(1'b1, cssu_pkg::ADDR_TXBUF, 32'h5E);
    for (int k = 0; k < 300 && rd[10:8] !== 3'h7; k++)
      apb(1'b0, cssu_pkg::ADDR_CTRL, 32'h0);
    check("reload flags", 32'h701, rd);
    check("reload tx data", 32'h5E, {24'h0, p_got});
    rdc(cssu_pkg::ADDR_IRQ_STAT, 32'h7, "overrun status");
    check("overrun irq", 32'h1, {31'h0, irq_out});
    rdc(cssu_pkg::ADDR_RXBUF, 32'h100, "overrun rx buffer");
    final_report;
  end
endmodule // test_clock_sync_serial_unit
